/* core/cgsc_pkg.sv */
package cgsc_pkg;

    // ----------------------------------------------------------------
    // Register offsets (hexadecimal byte addresses on the register port)
    // ----------------------------------------------------------------
    localparam logic [7:0] CGSC_ADDR_SERIAL_CFG = 8'h00;
    localparam logic [7:0] CGSC_ADDR_READBACK_SEL = 8'h04;
    localparam logic [7:0] CGSC_ADDR_COMMIT = 8'h05;
    localparam logic [7:0] CGSC_ADDR_CP_CURRENT = 8'h0A;
    localparam logic [7:0] CGSC_ADDR_LOOP_OVR = 8'h0B;
    localparam logic [7:0] CGSC_ADDR_ANTIBACKLASH = 8'h0D;

    // ----------------------------------------------------------------
    // Serial configuration field positions
    // ----------------------------------------------------------------
    localparam int CGSC_CFG_FOUR_WIRE_BIT = 7;
    localparam int CGSC_CFG_LSB_FIRST_BIT = 6;
    localparam int CGSC_CFG_SOFT_RESET_BIT = 5;
    localparam int CGSC_CFG_LONG_INSTR_BIT = 4;
    localparam int CGSC_READBACK_BIT = 0;
    localparam int CGSC_COMMIT_BIT = 0;

    // ----------------------------------------------------------------
    // Loop override register field positions
    // ----------------------------------------------------------------
    localparam int CGSC_OVR_CUR_EN_BIT = 7;
    localparam int CGSC_OVR_ABL_EN_BIT = 6;
    localparam int CGSC_OVR_MODE_HI = 5;
    localparam int CGSC_OVR_MODE_LO = 4;
    localparam int CGSC_OVR_MODE_EN_BIT = 3;
    localparam int CGSC_OVR_FB_EDGE_BIT = 2;
    localparam int CGSC_OVR_REF_EDGE_BIT = 1;
    localparam int CGSC_OVR_VCO_MID_BIT = 0;
    localparam int CGSC_ABL_HI = 7;
    localparam int CGSC_ABL_LO = 6;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] CGSC_RST_CP_CURRENT = 8'h80;
    localparam logic [7:0] CGSC_RST_LOOP_OVR = 8'h30;
    localparam logic [7:0] CGSC_RST_ANTIBACKLASH = 8'h00;
    localparam logic [7:0] CGSC_RST_AUTO_CURRENT = 8'h80;
    localparam logic [1:0] CGSC_RST_AUTO_ABL = 2'h0;

    // Charge pump mode encodings
    typedef enum logic [1:0] {
        CGSC_PUMP_TRISTATE = 2'h0,
        CGSC_PUMP_UP = 2'h1,
        CGSC_PUMP_DOWN = 2'h2,
        CGSC_PUMP_NORMAL = 2'h3
    } cgsc_pump_mode_type;

endpackage

/* core/cgsc_shadow_reg.sv */
`timescale 1ns/1ns
`default_nettype none

// Buffered register: host writes land in the pending copy, commit copies
// pending into active. Both copies return to the reset value on any reset.
module cgsc_shadow_reg #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic soft_rst_in,
    input wire logic wr_en_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic commit_in,
    output logic [WIDTH-1:0] pending_out,
    output logic [WIDTH-1:0] active_out
);

    logic [WIDTH-1:0] pending_reg;
    logic [WIDTH-1:0] active_reg;
    logic [WIDTH-1:0] pending_next;
    logic [WIDTH-1:0] active_next;

    // Commit takes the pending value as it stood before this cycle's write
    assign pending_next = wr_en_in ? wr_data_in : pending_reg;
    assign active_next = commit_in ? pending_reg : active_reg;

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pending_reg <= RESET_VALUE;
            active_reg <= RESET_VALUE;
        end else if (soft_rst_in) begin
            pending_reg <= RESET_VALUE;
            active_reg <= RESET_VALUE;
        end else begin
            pending_reg <= pending_next;
            active_reg <= active_next;
        end
    end

    assign pending_out = pending_reg;
    assign active_out = active_reg;

endmodule

`default_nettype wire

/* core/cgsc_regs.sv */
// Contract
// - Control bits are active high; addresses are hexadecimal.
// - Serial config bit 7 always reads zero: three-wire mode only.
// - Serial config bit 6 selects LSB-first; zero means MSB-first.
// - Writing serial config bit 5 resets all registers; bit self-clears.
// - Serial config bit 4 always reads one: 16-bit instruction mode.
// - Serial config bits 3:0 mirror bits 7:4.
// - Address 0x04 bit 0 selects active or pending readback of buffered registers.
// - Writing one to 0x05 bit 0 commits all buffered registers; self-clears.
// - Charge pump current defaults 0x80; effective only while 0x0B bit 7 set.
// - 0x0B bit 7 selects automatic or register-defined pump current.
// - 0x0B bit 6 selects automatic or 0x0D[7:6] antibacklash period.
// - Pump mode field 5:4: tristate, up, down, normal; resets to normal.
// - 0x0B bit 3 selects automatic or register-defined pump mode.
// - 0x0B bit 2 selects feedback edge: zero rising, one falling.
// - 0x0B bit 1 selects reference edge: zero rising, one falling.
// - 0x0B bit 0 forces oscillator control voltage to midscale.
`timescale 1ns/1ns
`default_nettype none

module cgsc_regs
    import cgsc_pkg::*;
#(
    parameter int ADDR_WIDTH = 8,
    parameter int DATA_WIDTH = 8
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // Byte-wide register port from the serial framing logic
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [ADDR_WIDTH-1:0] addr_in,
    input wire logic [DATA_WIDTH-1:0] wr_data_in,
    output logic [DATA_WIDTH-1:0] rd_data_out,
    output logic rd_valid_out,
    // Serial framing controls
    output logic lsb_first_out,
    // Automatic settings from the loop controller
    input wire logic [7:0] auto_pump_current_in,
    input wire logic [1:0] auto_pump_mode_in,
    input wire logic [1:0] auto_antibacklash_in,
    // Applied loop controls
    output logic [7:0] pump_current_out,
    output logic [1:0] charge_pump_mode_select_out,
    output logic [1:0] antibacklash_out,
    output logic fb_falling_edge_out,
    output logic ref_falling_edge_out,
    output logic vco_midscale_out,
    output logic soft_reset_pulse_out
);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (DATA_WIDTH != 8) begin : g_bad_data
        $error("cgsc_regs: DATA_WIDTH must be 8");
    end
    if (ADDR_WIDTH < 4 || ADDR_WIDTH > 8) begin : g_bad_addr
        $error("cgsc_regs: ADDR_WIDTH must be 4 to 8");
    end

    // Address compare widened to the package's 8-bit offsets
    function automatic logic addr_hit(input logic [ADDR_WIDTH-1:0] a, input logic [7:0] off);
        logic [7:0] wide;
        wide = 8'(a);
        return wide == off;
    endfunction

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire logic hit_cfg;
    wire logic hit_rbsel;
    wire logic hit_commit;
    wire logic hit_cur;
    wire logic hit_ovr;
    wire logic hit_abl;
    wire logic wr_cfg;
    wire logic soft_rst;
    wire logic commit;
    wire logic wr_cur;
    wire logic wr_ovr;
    wire logic wr_abl;

    assign hit_cfg = addr_hit(addr_in, CGSC_ADDR_SERIAL_CFG);
    assign hit_rbsel = addr_hit(addr_in, CGSC_ADDR_READBACK_SEL);
    assign hit_commit = addr_hit(addr_in, CGSC_ADDR_COMMIT);
    assign hit_cur = addr_hit(addr_in, CGSC_ADDR_CP_CURRENT);
    assign hit_ovr = addr_hit(addr_in, CGSC_ADDR_LOOP_OVR);
    assign hit_abl = addr_hit(addr_in, CGSC_ADDR_ANTIBACKLASH);

    assign wr_cfg = wr_en_in && hit_cfg;
    // Commit is one cycle wide and never stored, so it reads back as zero
    assign commit = wr_en_in && hit_commit && wr_data_in[CGSC_COMMIT_BIT];
    assign wr_cur = wr_en_in && hit_cur;
    assign wr_ovr = wr_en_in && hit_ovr;
    assign wr_abl = wr_en_in && hit_abl;

    // ----------------------------------------------------------------
    // Plain registers
    // ----------------------------------------------------------------
    logic lsb_first_reg;
    logic lsb_first_next;
    logic readback_pending_reg;
    logic readback_pending_next;
    logic soft_rst_reg;
    logic soft_rst_next;

    assign lsb_first_next = wr_cfg ? wr_data_in[CGSC_CFG_LSB_FIRST_BIT] : lsb_first_reg;
    // Only bit 0 is held; bits 7:1 are never stored
    assign readback_pending_next = (wr_en_in && hit_rbsel)
        ? wr_data_in[CGSC_READBACK_BIT] : readback_pending_reg;
    // A second request while the pulse stands is dropped with the rest of that
    // write, so the pulse never lasts longer than one cycle
    assign soft_rst_next = wr_cfg && wr_data_in[CGSC_CFG_SOFT_RESET_BIT]
        && !soft_rst_reg;
    // The soft reset acts in the cycle after the write; the write's other bits land first and are then cleared
    assign soft_rst = soft_rst_reg;

    // Configuration bits; soft reset returns them to defaults too
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            lsb_first_reg <= 1'b0;
            readback_pending_reg <= 1'b0;
        end else if (soft_rst) begin
            lsb_first_reg <= 1'b0;
            readback_pending_reg <= 1'b0;
        end else begin
            lsb_first_reg <= lsb_first_next;
            readback_pending_reg <= readback_pending_next;
        end
    end

    // Soft reset request, self-clearing after one cycle
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            soft_rst_reg <= 1'b0;
        end else begin
            soft_rst_reg <= soft_rst_next;
        end
    end

    // ----------------------------------------------------------------
    // Buffered loop registers
    // ----------------------------------------------------------------
    logic [7:0] cur_pending;
    logic [7:0] cur_active;
    logic [7:0] ovr_pending;
    logic [7:0] ovr_active;
    logic [7:0] abl_pending;
    logic [7:0] abl_active;
    logic [7:0] abl_wr_data;

    // Only bits 7:6 and bit 0 exist; unused bits are kept zero
    assign abl_wr_data = {wr_data_in[CGSC_ABL_HI:CGSC_ABL_LO], 5'h00, wr_data_in[0]};

    cgsc_shadow_reg #(
        .WIDTH(8),
        .RESET_VALUE(CGSC_RST_CP_CURRENT)
    ) u_cur (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .soft_rst_in(soft_rst),
        .wr_en_in(wr_cur),
        .wr_data_in(wr_data_in),
        .commit_in(commit),
        .pending_out(cur_pending),
        .active_out(cur_active)
    );

    cgsc_shadow_reg #(
        .WIDTH(8),
        .RESET_VALUE(CGSC_RST_LOOP_OVR)
    ) u_ovr (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .soft_rst_in(soft_rst),
        .wr_en_in(wr_ovr),
        .wr_data_in(wr_data_in),
        .commit_in(commit),
        .pending_out(ovr_pending),
        .active_out(ovr_active)
    );

    cgsc_shadow_reg #(
        .WIDTH(8),
        .RESET_VALUE(CGSC_RST_ANTIBACKLASH)
    ) u_abl (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .soft_rst_in(soft_rst),
        .wr_en_in(wr_abl),
        .wr_data_in(abl_wr_data),
        .commit_in(commit),
        .pending_out(abl_pending),
        .active_out(abl_active)
    );

    // ----------------------------------------------------------------
    // Applied loop controls
    // ----------------------------------------------------------------
    wire logic [7:0] cur_sel;
    wire logic [1:0] mode_sel;
    wire logic [1:0] abl_sel;

    // Each override steers the loop only from the active copy, so a half
    // written setting never reaches the analog side before commit
    assign cur_sel = ovr_active[CGSC_OVR_CUR_EN_BIT]
        ? cur_active : auto_pump_current_in;
    assign abl_sel = ovr_active[CGSC_OVR_ABL_EN_BIT]
        ? abl_active[CGSC_ABL_HI:CGSC_ABL_LO] : auto_antibacklash_in;
    assign mode_sel = ovr_active[CGSC_OVR_MODE_EN_BIT]
        ? ovr_active[CGSC_OVR_MODE_HI:CGSC_OVR_MODE_LO] : auto_pump_mode_in;

    logic [7:0] pump_current_reg;
    logic [1:0] pump_mode_reg;
    logic [1:0] antibacklash_reg;
    logic fb_edge_reg;
    logic ref_edge_reg;
    logic vco_mid_reg;

    // Registered so every output comes from a flip-flop. The applied values
    // trail the active copy by one cycle, which the loop side must tolerate;
    // in return no decode path reaches the analog controls directly.

    // Applied pump current: the register value only while its override is set,
    // otherwise the loop's own choice
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pump_current_reg <= CGSC_RST_AUTO_CURRENT;
        end else begin
            pump_current_reg <= cur_sel;
        end
    end

    // Applied pump mode; resets to normal so the loop runs before any write
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pump_mode_reg <= CGSC_PUMP_NORMAL;
        end else begin
            pump_mode_reg <= mode_sel;
        end
    end

    // Applied antibacklash period
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            antibacklash_reg <= CGSC_RST_AUTO_ABL;
        end else begin
            antibacklash_reg <= abl_sel;
        end
    end

    // Feedback input edge select: low picks the rising edge
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            fb_edge_reg <= 1'b0;
        end else begin
            fb_edge_reg <= ovr_active[CGSC_OVR_FB_EDGE_BIT];
        end
    end

    // Reference input edge select: low picks the rising edge
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ref_edge_reg <= 1'b0;
        end else begin
            ref_edge_reg <= ovr_active[CGSC_OVR_REF_EDGE_BIT];
        end
    end

    // Midscale force; cleared by reset so the oscillator starts free
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            vco_mid_reg <= 1'b0;
        end else begin
            vco_mid_reg <= ovr_active[CGSC_OVR_VCO_MID_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Readback
    // ----------------------------------------------------------------
    wire logic [3:0] cfg_upper;
    wire logic [7:0] cfg_read;
    wire logic [7:0] rb_cur;
    wire logic [7:0] rb_ovr;
    wire logic [7:0] rb_abl;
    logic [7:0] rd_mux;

    // Bit 7 forced low, bit 4 forced high, soft reset reads as zero
    assign cfg_upper = {1'b0, lsb_first_reg, 1'b0, 1'b1};
    assign cfg_read = {cfg_upper, cfg_upper};

    assign rb_cur = readback_pending_reg ? cur_pending : cur_active;
    assign rb_ovr = readback_pending_reg ? ovr_pending : ovr_active;
    assign rb_abl = readback_pending_reg ? abl_pending : abl_active;

    // Unmapped addresses read as zero
    always_comb begin
        rd_mux = 8'h00;
        if (hit_cfg) begin
            rd_mux = cfg_read;
        end else if (hit_rbsel) begin
            rd_mux = {7'h00, readback_pending_reg};
        end else if (hit_commit) begin
            rd_mux = 8'h00;
        end else if (hit_cur) begin
            rd_mux = rb_cur;
        end else if (hit_ovr) begin
            rd_mux = rb_ovr;
        end else if (hit_abl) begin
            rd_mux = rb_abl;
        end
    end

    logic [7:0] rd_data_reg;
    logic rd_valid_reg;

    // Read data registered one cycle after the strobe
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_data_reg <= 8'h00;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_data_reg <= rd_en_in ? rd_mux : rd_data_reg;
            rd_valid_reg <= rd_en_in;
        end
    end

    assign rd_data_out = rd_data_reg;
    assign rd_valid_out = rd_valid_reg;
    assign lsb_first_out = lsb_first_reg;
    assign pump_current_out = pump_current_reg;
    assign charge_pump_mode_select_out = pump_mode_reg;
    assign antibacklash_out = antibacklash_reg;
    assign fb_falling_edge_out = fb_edge_reg;
    assign ref_falling_edge_out = ref_edge_reg;
    assign vco_midscale_out = vco_mid_reg;
    assign soft_reset_pulse_out = soft_rst_reg;

endmodule

`default_nettype wire

/* test/cgsc_regs_monitor.sv */
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// Port checks of the register bank
// ----------------------------------------------------------------
module cgsc_regs_monitor
    import cgsc_pkg::*;
#(
    parameter int ADDR_WIDTH = 8,
    parameter int DATA_WIDTH = 8
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [ADDR_WIDTH-1:0] addr_in,
    input wire logic [DATA_WIDTH-1:0] wr_data_in,
    input wire logic [DATA_WIDTH-1:0] rd_data_out,
    input wire logic rd_valid_out,
    input wire logic lsb_first_out,
    input wire logic fb_falling_edge_out,
    input wire logic ref_falling_edge_out,
    input wire logic vco_midscale_out,
    input wire logic soft_reset_pulse_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    // Decoded requests seen on the byte port
    wire cfg_rd = rd_en_in && (addr_in == CGSC_ADDR_SERIAL_CFG);
    wire unused_rd = rd_en_in && (addr_in == CGSC_ADDR_READBACK_SEL || addr_in == CGSC_ADDR_COMMIT);
    wire soft_wr = wr_en_in && (addr_in == CGSC_ADDR_SERIAL_CFG) && wr_data_in[5];
    wire commit_wr = wr_en_in && (addr_in == CGSC_ADDR_COMMIT) && wr_data_in[0];

    AST_RD_ANSWER: assert property (rd_valid_out == $past(rd_en_in))
        else $error("read answer not exactly one cycle after strobe");
    AST_CFG_B7_ZERO: assert property (cfg_rd |=> !rd_data_out[7])
        else $error("config bit 7 read as one");
    AST_CFG_B4_ONE: assert property (cfg_rd |=> rd_data_out[4])
        else $error("config bit 4 read as zero");
    AST_CFG_MIRROR: assert property (cfg_rd |=> rd_data_out[3:0] == rd_data_out[7:4])
        else $error("config low nibble does not mirror high nibble");
    AST_UNUSED_ZERO: assert property (unused_rd |=> rd_data_out[7:1] == 7'h00)
        else $error("unused bits of readback or commit byte not zero");
    AST_SOFT_PULSE: assert property (soft_wr && !soft_reset_pulse_out |=> soft_reset_pulse_out)
        else $error("soft reset write gave no pulse");
    AST_SOFT_CLEAR: assert property (soft_reset_pulse_out |=> !soft_reset_pulse_out)
        else $error("soft reset bit did not clear itself");
    // Applied copies land two cycles after the pulse, so a write right after cannot reach them
    AST_SOFT_DEFAULTS: assert property (soft_reset_pulse_out |-> ##2
        !(vco_midscale_out || fb_falling_edge_out || ref_falling_edge_out || lsb_first_out))
        else $error("soft reset left a control set");
    AST_VCO_ON_COMMIT: assert property ($rose(vco_midscale_out) |-> $past(commit_wr, 2))
        else $error("midscale force applied without commit");
    AST_EDGE_ON_COMMIT: assert property (
        $changed({fb_falling_edge_out, ref_falling_edge_out}) |->
        ($past(commit_wr, 2) || $past(soft_reset_pulse_out, 2) || $past(soft_reset_pulse_out)))
        else $error("edge select changed without commit or soft reset");

    COV_CFG_READ: cover property (cfg_rd);
    COV_COMMIT: cover property (commit_wr);
    COV_SOFT: cover property (soft_reset_pulse_out);
endmodule

bind cgsc_regs cgsc_regs_monitor #(.ADDR_WIDTH(ADDR_WIDTH), .DATA_WIDTH(DATA_WIDTH)) u_monitor (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .rd_data_out(rd_data_out),
    .rd_valid_out(rd_valid_out), .lsb_first_out(lsb_first_out),
    .fb_falling_edge_out(fb_falling_edge_out), .ref_falling_edge_out(ref_falling_edge_out),
    .vco_midscale_out(vco_midscale_out), .soft_reset_pulse_out(soft_reset_pulse_out));

`default_nettype wire

/* test/cgsc_host_model.sv */
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// Host controller issuing single-byte register accesses
// ----------------------------------------------------------------
module cgsc_host_model (
    input wire logic sys_clk_in,
    input wire logic [7:0] rd_data_in,
    input wire logic rd_valid_in,
    input wire logic lsb_first_in,
    output logic wr_en_out,
    output logic rd_en_out,
    output logic [7:0] addr_out,
    output logic [7:0] wr_data_out
);
    logic host_lsb_reg = 1'b0;

    initial begin
        wr_en_out = 1'b0;
        rd_en_out = 1'b0;
        addr_out = 8'h00;
        wr_data_out = 8'h00;
    end

    // Framing follows the bit order the device reports
    always @(posedge sys_clk_in) host_lsb_reg <= lsb_first_in;

    // Idle lines flip so a stale address never passes for a live one
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        wr_en_out <= 1'b1;
        addr_out <= a;
        wr_data_out <= d;
        @(posedge sys_clk_in);
        wr_en_out <= 1'b0;
        addr_out <= ~a;
        wr_data_out <= ~d;
    endtask

    // Data is taken one edge after the strobe, while valid stands
    task automatic read(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge sys_clk_in);
        rd_en_out <= 1'b1;
        addr_out <= a;
        @(posedge sys_clk_in);
        rd_en_out <= 1'b0;
        addr_out <= ~a;
        #1;
        d = rd_data_in;
        v = rd_valid_in;
    endtask
endmodule

`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none

`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    $display("ERROR %s expected %h seen %h", n, e, g); err_count++; end end

module tb_top
    import cgsc_pkg::*;
;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic wr_en, rd_en, lsb, fb, rf, vco, pulse, rd_valid;
    logic [7:0] addr, wr_data, rd_data, pump;
    logic [7:0] cur_auto = 8'h3C;
    logic [1:0] mode_auto = 2'h1;
    logic [1:0] abl_auto = 2'h2;
    logic [1:0] mode, abl;
    int err_count = 0;
    int cmp_count = 0;
    int cycles = 0;

    initial forever #20 sys_clk_in = ~sys_clk_in;

    cgsc_regs dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .wr_en_in(wr_en), .rd_en_in(rd_en),
        .addr_in(addr), .wr_data_in(wr_data), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
        .lsb_first_out(lsb), .auto_pump_current_in(cur_auto), .auto_pump_mode_in(mode_auto),
        .auto_antibacklash_in(abl_auto), .pump_current_out(pump),
        .charge_pump_mode_select_out(mode), .antibacklash_out(abl), .fb_falling_edge_out(fb),
        .ref_falling_edge_out(rf), .vco_midscale_out(vco), .soft_reset_pulse_out(pulse));

    cgsc_host_model host (.sys_clk_in(sys_clk_in), .rd_data_in(rd_data), .rd_valid_in(rd_valid),
        .lsb_first_in(lsb), .wr_en_out(wr_en), .rd_en_out(rd_en), .addr_out(addr),
        .wr_data_out(wr_data));

    // ----------------------------------------------------------------
    // Access and comparison helpers
    // ----------------------------------------------------------------
    task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string n);
        logic [7:0] d;
        logic v;
        host.read(a, d, v);
        `CHK("rd_valid", 1'b1, v)
        `CHK(n, e, d)
    endtask

    // Applied controls lag the commit by two cycles; three leaves margin
    task automatic outs(input logic [7:0] p, input logic [1:0] m, input logic [1:0] b,
        input logic [2:0] e);
        repeat (3) @(posedge sys_clk_in);
        #1;
        `CHK("pump_current", p, pump)
        `CHK("pump_mode", m, mode)
        `CHK("antibacklash", b, abl)
        `CHK("edges_vco", e, {fb, rf, vco})
    endtask

    task automatic end_of_test();
        if (err_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // A hung access is cut short well past the expected run length
    always @(posedge sys_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            end_of_test();
        end
    end

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        int i;
        repeat (10) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        rchk(8'h00, 8'h11, "cfg");
        rchk(8'h04, 8'h00, "rb_sel");
        rchk(8'h0A, 8'h80, "cur");
        rchk(8'h0B, 8'h30, "ovr");
        outs(cur_auto, mode_auto, abl_auto, 3'h0);
        // Pending values stay inactive until committed; readback shows them only with 0x04 bit 0 set
        host.write(8'h0B, 8'hFF);
        host.write(8'h07, 8'hFF);
        rchk(8'h07, 8'h00, "unmapped");
        rchk(8'h0B, 8'h30, "ovr_active");
        host.write(8'h04, 8'hFF);
        rchk(8'h04, 8'h01, "rb_sel_set");
        rchk(8'h0B, 8'hFF, "ovr_pending");
        outs(cur_auto, mode_auto, abl_auto, 3'h0);
        // Every pump mode code, with all overrides taken from the registers
        for (i = 0; i < 4; i++) begin
            host.write(8'h0A, 8'h10 + i[7:0]);
            host.write(8'h0B, {2'b11, i[1:0], 1'b1, i[0], i[1], i[0]});
            host.write(8'h0D, {i[1:0], 6'h01});
            host.write(8'h05, 8'hFF);
            rchk(8'h05, 8'h00, "commit_clear");
            outs(8'h10 + i[7:0], i[1:0], i[1:0], {i[0], i[1], i[0]});
        end
        host.write(8'h00, 8'hC0);
        rchk(8'h00, 8'h55, "cfg_lsb");
        `CHK("lsb_first", 1'b1, lsb)
        `CHK("host_lsb", 1'b1, host.host_lsb_reg)
        host.write(8'h00, 8'h20);
        rchk(8'h00, 8'h11, "cfg_soft");
        rchk(8'h04, 8'h00, "rb_sel_soft");
        rchk(8'h0B, 8'h30, "ovr_soft");
        rchk(8'h0A, 8'h80, "cur_soft");
        `CHK("lsb_soft", 1'b0, lsb)
        `CHK("host_lsb_soft", 1'b0, host.host_lsb_reg)
        outs(cur_auto, mode_auto, abl_auto, 3'h0);
        end_of_test();
    end
endmodule

`default_nettype wire
